// file: cspc_pkg.sv
// constants, field layouts and carrier types for the clock status and programmable clock block
// Functional notes
// - source select 0 slow, 1 main, 2 pll a, 3 pll b.
// - prescale divides selected source by two to the code; code 7 reserved.
// - prescale in bits 4..2, source select in bits 1..0, rest unused.
// - flags at bits 0,1,2,3 and programmable clock ready at 8,9.
// - ones written to enable command set enables; zeros change nothing.
// - ones written to disable command clear enables; zeros change nothing.
// - mask view reads 0 for enabled, 1 for disabled.
// - main oscillator stable bit reads 1 once stabilized.
// - each pll lock bit reads 1 while that pll is locked.
// - master clock ready bit reads 1 while master clock is ready.
// - status bit 7 reads slow clock source, 0 rc, 1 crystal.
// - programmable clock ready bits read 1 when that output is ready.
`default_nettype none
package cspc_pkg;

    // byte addresses of the registers
    localparam logic [31:0] ADDR_PCK0   = 32'h0ffffc40;
    localparam logic [31:0] ADDR_PCK1   = 32'h0ffffc44;
    localparam logic [31:0] ADDR_IEN    = 32'h0ffffc60;
    localparam logic [31:0] ADDR_IDIS   = 32'h0ffffc64;
    localparam logic [31:0] ADDR_STAT   = 32'h0ffffc68;
    localparam logic [31:0] ADDR_MASK   = 32'h0ffffc6c;
    localparam logic [31:0] ADDR_EVT    = 32'h0ffffc70;
    localparam logic [31:0] ADDR_EVTCLR = 32'h0ffffc74;
    localparam logic [31:0] ADDR_PUMP   = 32'h0ffffc80;

    // status, interrupt and pump bit positions
    localparam int BIT_MOSC   = 0;
    localparam int BIT_PLL_A_LOCKED  = 1;
    localparam int BIT_PLL_B_LOCKED  = 2;
    localparam int BIT_MCK    = 3;
    localparam int BIT_SLOSC  = 7;
    localparam int BIT_PCK0   = 8;
    localparam int BIT_PCK1   = 9;
    localparam int BIT_PUMP_A = 0;
    localparam int BIT_PUMP_B = 16;

    // bits that carry an interrupt source, and the pump bits that are kept
    localparam logic [31:0] IRQ_BITS  = 32'h0000030f;
    localparam logic [31:0] PUMP_BITS = 32'h00010001;

    // programmable clock field layout
    localparam int PCK_SRC_LSB = 0;
    localparam int PCK_PRE_LSB = 2;
    localparam logic [2:0] PRE_RESERVED = 3'h7;

    // source select codes
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLLA = 2'h2;
    localparam logic [1:0] SRC_PLLB = 2'h3;

    // values after reset
    localparam logic [4:0]  PCK_RESET  = 5'h00;
    localparam logic [9:0]  IEN_RESET  = 10'h000;
    localparam logic [31:0] PUMP_RESET = 32'h00000000;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // programmable clock configuration
    typedef struct packed {
        logic [2:0] prescale_sel;
        logic [1:0] clock_source_sel;
    } cspc_pck_cfg_t;

    // raw status inputs
    typedef struct packed {
        logic slow_osc_source;
        logic master_clk_ready;
        logic pll_b_locked;
        logic pll_a_locked;
        logic main_osc_stable;
    } cspc_osc_stat_t;

endpackage : cspc_pkg
`default_nettype wire

// file: cspc_top.sv
// clock status registers, interrupt logic and programmable clock dividers behind axi4-lite
`timescale 1ns/1ps
`default_nettype none
module cspc_top
    import cspc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // oscillator and clock status levels
    input  wire logic        main_osc_stable,
    input  wire logic        pll_a_locked,
    input  wire logic        pll_b_locked,
    input  wire logic        master_clk_ready,
    input  wire logic        slow_osc_source,
    // source clock enables: slow, main, pll a, pll b
    input  wire logic [3:0]  src_tick,
    // programmable clock enables and pump current settings
    output logic [1:0]       prog_clk_tick,
    output logic             pll_a_pump_current,
    output logic             pll_b_pump_current,
    // interrupt
    output logic             irq
);

    // low code gives a limit of 2^code - 1 source ticks
    function automatic logic [5:0] div_limit(input logic [2:0] pre);
        logic [6:0] full;
        full = 7'h01 << pre;
        div_limit = 6'(full - 7'h01);
    endfunction : div_limit

    // byte lane merge for read/write registers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    // picks the enable pulse of the selected source
    function automatic logic sel_tick(input logic [3:0] ticks, input logic [1:0] src);
        logic t;
        case (src)
            SRC_SLOW: t = ticks[0];
            SRC_MAIN: t = ticks[1];
            SRC_PLLA: t = ticks[2];
            SRC_PLLB: t = ticks[3];
            default:  t = 1'b0;
        endcase
        sel_tick = t;
    endfunction : sel_tick

    // state
    cspc_pck_cfg_t  pck_q [2];
    logic [5:0]     div_cnt_q [2];
    logic [1:0]     pck_ready_q;
    logic [1:0]     pck_tick_q;
    logic [9:0]     ien_q;
    logic [9:0]     evt_q;
    logic [31:0]    stat_prev_q;
    logic [31:0]    pump_q;
    logic           bvalid_q;
    logic [1:0]     bresp_q;
    logic           rvalid_q;
    logic [1:0]     rresp_q;
    logic [31:0]    rdata_q;
    cspc_osc_stat_t osc;

    // write channel takes address and data together, one write at a time
    logic        wr_fire;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic        wr_pck0;
    logic        wr_pck1;
    logic        wr_ien;
    logic        wr_idis;
    logic        wr_evtclr;
    logic        wr_pump;
    logic        wr_ro;
    logic        wr_hit;
    assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wbits     = s_axi_wdata & wmask;
    assign wr_pck0   = wr_fire & (s_axi_awaddr == ADDR_PCK0);
    assign wr_pck1   = wr_fire & (s_axi_awaddr == ADDR_PCK1);
    assign wr_ien    = wr_fire & (s_axi_awaddr == ADDR_IEN);
    assign wr_idis   = wr_fire & (s_axi_awaddr == ADDR_IDIS);
    assign wr_evtclr = wr_fire & (s_axi_awaddr == ADDR_EVTCLR);
    assign wr_pump   = wr_fire & (s_axi_awaddr == ADDR_PUMP);
    // writes to read-only words are accepted and dropped
    assign wr_ro     = (s_axi_awaddr == ADDR_STAT) | (s_axi_awaddr == ADDR_MASK) |
                       (s_axi_awaddr == ADDR_EVT);
    assign wr_hit    = wr_pck0 | wr_pck1 | wr_ien | wr_idis | wr_evtclr | wr_pump |
                       (wr_fire & wr_ro);

    // new configuration values after byte lanes
    logic [31:0] pck0_word;
    logic [31:0] pck1_word;
    logic [31:0] pck0_new;
    logic [31:0] pck1_new;
    assign pck0_word = {27'h0, pck_q[0]};
    assign pck1_word = {27'h0, pck_q[1]};
    assign pck0_new  = merge(pck0_word, s_axi_wdata, s_axi_wstrb);
    assign pck1_new  = merge(pck1_word, s_axi_wdata, s_axi_wstrb);

    // status word assembled from levels and divider state
    logic [31:0] stat_word;
    logic [31:0] mask_word;
    logic [31:0] evt_word;
    logic [31:0] rise;
    assign osc = '{slow_osc_source:  slow_osc_source,
                   master_clk_ready: master_clk_ready,
                   pll_b_locked:     pll_b_locked,
                   pll_a_locked:     pll_a_locked,
                   main_osc_stable:  main_osc_stable};
    always_comb begin
        stat_word            = 32'h00000000;
        stat_word[BIT_MOSC]  = osc.main_osc_stable;
        stat_word[BIT_PLL_A_LOCKED] = osc.pll_a_locked;
        stat_word[BIT_PLL_B_LOCKED] = osc.pll_b_locked;
        stat_word[BIT_MCK]   = osc.master_clk_ready;
        stat_word[BIT_SLOSC] = osc.slow_osc_source;
        stat_word[BIT_PCK0]  = pck_ready_q[0];
        stat_word[BIT_PCK1]  = pck_ready_q[1];
    end
    // mask view is the inverse of the enables, as the word is laid out
    assign mask_word = ~{22'h0, ien_q} & IRQ_BITS;
    assign evt_word  = {22'h0, evt_q};
    // rising edge of any interrupt-bearing status bit
    assign rise      = stat_word & ~stat_prev_q & IRQ_BITS;

    // read decode; unmapped addresses answer slverr with zero data
    logic        rd_fire;
    logic [31:0] rd_data;
    logic        rd_hit;
    assign rd_fire       = s_axi_arvalid & ~rvalid_q;
    assign s_axi_arready = ~rvalid_q;
    always_comb begin
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            ADDR_PCK0: rd_data = pck0_word;
            ADDR_PCK1: rd_data = pck1_word;
            ADDR_STAT: rd_data = stat_word;
            ADDR_MASK: rd_data = mask_word;
            ADDR_EVT:  rd_data = evt_word;
            ADDR_PUMP: rd_data = pump_q;
            ADDR_IEN:  rd_data = 32'h00000000;  // write-only words read as zero
            ADDR_IDIS: rd_data = 32'h00000000;
            ADDR_EVTCLR: rd_data = 32'h00000000;
            default: begin
                rd_data = 32'h00000000;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // enable and disable commands; only interrupt-bearing bits are kept, so the
    // slow source flag at bit 7 can never raise the interrupt
    logic [9:0] ien_d;
    assign ien_d = (ien_q | (wr_ien ? wbits[9:0] : 10'h000))
                   & ~(wr_idis ? wbits[9:0] : 10'h000)
                   & IRQ_BITS[9:0];

    // sticky events: a new edge wins over a clear in the same cycle
    logic [9:0] evt_d;
    assign evt_d = (evt_q & ~(wr_evtclr ? wbits[9:0] : 10'h000)) | rise[9:0];

    // interrupt level from live flags and latched edges
    assign irq = |((stat_word[9:0] | evt_q) & ien_q);

    // configuration and interrupt registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pck_q[0]    <= PCK_RESET;
            pck_q[1]    <= PCK_RESET;
            ien_q       <= IEN_RESET;
            evt_q       <= 10'h000;
            stat_prev_q <= 32'h00000000;
            pump_q      <= PUMP_RESET;
        end else begin
            if (wr_pck0) begin
                pck_q[0] <= pck0_new[4:0];
            end
            if (wr_pck1) begin
                pck_q[1] <= pck1_new[4:0];
            end
            // only the two pump bits are kept; software is expected to set both
            if (wr_pump) begin
                pump_q <= merge(pump_q, s_axi_wdata, s_axi_wstrb) & PUMP_BITS;
            end
            ien_q       <= ien_d;
            evt_q       <= evt_d;
            stat_prev_q <= stat_word;
        end
    end

    assign pll_a_pump_current = pump_q[BIT_PUMP_A];
    assign pll_b_pump_current = pump_q[BIT_PUMP_B];

    // divider per programmable clock; a reconfiguration restarts the count
    logic [1:0] cfg_wr;
    logic [1:0] src_sel;
    logic [1:0] wrap;
    logic [1:0] chan_off;
    assign cfg_wr = {wr_pck1, wr_pck0};
    genvar g;
    for (g = 0; g < 2; g++) begin : g_pck
        assign src_sel[g]  = sel_tick(src_tick, pck_q[g].clock_source_sel);
        assign chan_off[g] = (pck_q[g].prescale_sel == PRE_RESERVED);
        assign wrap[g]     = (div_cnt_q[g] >= div_limit(pck_q[g].prescale_sel));

        // count source ticks and pulse once every 2^code of them for codes 0 to 6
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                div_cnt_q[g]   <= 6'h00;
                pck_tick_q[g]  <= 1'b0;
                pck_ready_q[g] <= 1'b0;
            end else if (cfg_wr[g]) begin
                // ready drops until the new setting has produced an edge
                div_cnt_q[g]   <= 6'h00;
                pck_tick_q[g]  <= 1'b0;
                pck_ready_q[g] <= 1'b0;
            end else if (chan_off[g]) begin
                // reserved code stops the output rather than guessing a ratio
                div_cnt_q[g]   <= 6'h00;
                pck_tick_q[g]  <= 1'b0;
                pck_ready_q[g] <= 1'b0;
            end else if (src_sel[g]) begin
                div_cnt_q[g]   <= wrap[g] ? 6'h00 : 6'(div_cnt_q[g] + 6'h01);
                pck_tick_q[g]  <= wrap[g];
                pck_ready_q[g] <= pck_ready_q[g] | wrap[g];
            end else begin
                pck_tick_q[g]  <= 1'b0;
            end
        end
    end

    assign prog_clk_tick = pck_tick_q;

    // write response one cycle after both channels are taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h00000000;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= rd_data;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

endmodule : cspc_top
`default_nettype wire

// file: cspc_monitor.sv
// checker on the ports of the clock status block
`timescale 1ns/1ps
`default_nettype none
module cspc_monitor
    import cspc_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    // status levels and outputs
    input wire logic        main_osc_stable,
    input wire logic        pll_a_locked,
    input wire logic        pll_b_locked,
    input wire logic        master_clk_ready,
    input wire logic        slow_osc_source,
    input wire logic [3:0]  src_tick,
    input wire logic [1:0]  prog_clk_tick,
    input wire logic        pll_a_pump_current,
    input wire logic        pll_b_pump_current,
    input wire logic        irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus takes; status is copied into read data at the take edge
    wire wr_go = s_axi_awvalid && s_axi_awready;
    wire pump_wr = wr_go && s_axi_awaddr == ADDR_PUMP;
    wire st_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STAT;
    wire off_wr = wr_go && s_axi_awaddr == ADDR_IDIS && s_axi_wdata[9:0] == 10'h30f
                  && s_axi_wstrb[1:0] == 2'h3;
    pump_a_kept_a: assert property (
        pump_wr && s_axi_wstrb[0] |=> pll_a_pump_current == $past(s_axi_wdata[0]))
        else $error("pump a bit wrong");
    pump_b_kept_a: assert property (
        pump_wr && s_axi_wstrb[2] |=> pll_b_pump_current == $past(s_axi_wdata[16]))
        else $error("pump b bit wrong");
    osc_bit_a: assert property (st_rd |=> s_axi_rdata[0] == $past(main_osc_stable))
        else $error("osc stable bit wrong");
    lock_bits_a: assert property (st_rd |=> s_axi_rdata[1] == $past(pll_a_locked)
        && s_axi_rdata[2] == $past(pll_b_locked))
        else $error("lock bits wrong");
    mck_bit_a: assert property (st_rd |=> s_axi_rdata[3] == $past(master_clk_ready))
        else $error("master clock bit wrong");
    slow_src_a: assert property (st_rd |=> s_axi_rdata[7] == $past(slow_osc_source))
        else $error("slow source bit wrong");
    tick_cause_a: assert property (prog_clk_tick[0] |-> $past(src_tick) != 4'h0)
        else $error("tick without source pulse");
    irq_off_a: assert property (off_wr |=> !irq)
        else $error("irq after disable all");
    // main scenarios reached
    irq_seen_c: cover property (irq);
    tick1_c: cover property (prog_clk_tick[1]);
    pump_c: cover property (pll_a_pump_current && pll_b_pump_current);
endmodule : cspc_monitor
bind cspc_top cspc_monitor cspc_monitor_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .main_osc_stable, .pll_a_locked, .pll_b_locked, .master_clk_ready, .slow_osc_source,
    .src_tick, .prog_clk_tick, .pll_a_pump_current, .pll_b_pump_current, .irq);
`default_nettype wire

// file: cspc_tb_top.sv
// self-checking bench for the clock status block
`timescale 1ns/1ps
`default_nettype none
module cspc_tb_top import cspc_pkg::*; ;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, pa, pb, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, got;
    logic [1:0]  bresp, rresp, ptick;
    logic [3:0]  src_tick;
    logic [4:0]  st;
    int          error_cnt = 0, compares = 0, t0 = 0, t1 = 0, b, i;
    cspc_top cspc_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .main_osc_stable(st[0]),
        .pll_a_locked(st[1]), .pll_b_locked(st[2]), .master_clk_ready(st[3]),
        .slow_osc_source(st[4]), .src_tick(src_tick), .prog_clk_tick(ptick),
        .pll_a_pump_current(pa), .pll_b_pump_current(pb), .irq(irq));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // divided clock pulses counted per channel
    always @(posedge aclk) begin
        t0 <= t0 + int'(ptick[0]);
        t1 <= t1 + int'(ptick[1]);
    end
    task automatic give_verdict;
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // bounded wait for one handshake: 0 aw/w, 1 b, 2 ar, 3 r
    task automatic wait_for(input int k);
        logic h;
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            h = (k == 0) ? (awready & wready) : (k == 1) ? bvalid : (k == 2) ? arready : rvalid;
            if (h === 1'b1) return;
        end
        chk("handshake", 32'h1, 32'h0);
        give_verdict();
    endtask : wait_for
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wait_for(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        wait_for(1);
        bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, bresp});
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a, input logic [1:0] r, output logic [31:0] v);
        araddr <= a;
        arvalid <= 1'b1;
        wait_for(2);
        arvalid <= 1'b0;
        rready <= 1'b1;
        wait_for(3);
        rready <= 1'b0;
        v = rdata;
        chk("rresp", {30'h0, r}, {30'h0, rresp});
    endtask : axi_rd
    task automatic rd_chk(input string nm, input logic [31:0] a, m, e);
        logic [31:0] v;
        axi_rd(a, RESP_OKAY, v);
        chk(nm, e, v & m);
    endtask : rd_chk
    // one-cycle source pulses, two apart, then time for the tick to land
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            src_tick <= 4'h1 << k;
            @(posedge aclk);
            src_tick <= 4'h0;
            @(posedge aclk);
        end
        repeat (2) @(posedge aclk);
    endtask : pulse
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, wdata, araddr, src_tick, st} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk("mask", ADDR_MASK, '1, 32'h30f);
        rd_chk("pck0", ADDR_PCK0, '1, 32'h0);
        axi_wr(ADDR_PUMP, '1, RESP_OKAY);
        rd_chk("pump", ADDR_PUMP, '1, 32'h10001);
        chk("pump_out", 32'h3, {30'h0, pb, pa});
        // each status level on its own bit
        for (i = 0; i < 5; i++) begin
            st <= 5'h1 << i;
            @(posedge aclk);
            got = (i < 4) ? 32'h1 << i : 32'h80;
            rd_chk("status", ADDR_STAT, 32'h8f, got);
        end
        // interrupt enable, zero writes, disable; events cleared as bit 0 rises, set wins
        st <= 5'h1;
        axi_wr(ADDR_EVTCLR, 32'h30f, RESP_OKAY);
        rd_chk("evt", ADDR_EVT, '1, 32'h1);
        chk("irq_idle", 32'h0, {31'h0, irq});
        axi_wr(ADDR_IEN, 32'h1, RESP_OKAY);
        axi_wr(ADDR_IEN, 32'h0, RESP_OKAY);
        axi_wr(ADDR_IDIS, 32'h0, RESP_OKAY);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd_chk("mask", ADDR_MASK, '1, 32'h30e);
        axi_wr(ADDR_IDIS, 32'h30f, RESP_OKAY);
        chk("irq_off", 32'h0, {31'h0, irq});
        rd_chk("mask", ADDR_MASK, '1, 32'h30f);
        // the slow source flag carries no interrupt, even if its enable bit is written
        st <= 5'h10;
        axi_wr(ADDR_IEN, 32'h80, RESP_OKAY);
        chk("irq_slow", 32'h0, {31'h0, irq});
        axi_rd(32'h0ffffc90, RESP_SLVERR, got);
        chk("unmapped", 32'h0, got);
        axi_wr(32'h0ffffc90, 32'h1, RESP_SLVERR);
        axi_wr(ADDR_IEN, 32'h200, RESP_OKAY);
        // channel 1 counts only its selected source
        for (i = 0; i < 4; i++) begin
            axi_wr(ADDR_PCK1, 32'h4 | i, RESP_OKAY);
            rd_chk("pck1", ADDR_PCK1, '1, 32'h4 | i);
            b = t1;
            pulse((i + 1) % 4, 2);
            chk("foreign", b, t1);
            pulse(i, 2);
            chk("own", b + 1, t1);
        end
        rd_chk("ready1", ADDR_STAT, 32'h200, 32'h200);
        chk("irq_ready", 32'h1, {31'h0, irq});
        // every prescale code: one pulse short, then on the count; code 7 stays off
        for (i = 0; i < 8; i++) begin
            axi_wr(ADDR_PCK0, (i << 2) | 1, RESP_OKAY);
            b = t0;
            pulse(1, (1 << i) - 1);
            chk("short", b, t0);
            pulse(1, 1);
            chk("div", b + int'(i < 7), t0);
            rd_chk("ready0", ADDR_STAT, 32'h100, (i < 7) ? 32'h100 : 32'h0);
        end
        give_verdict();
    end
endmodule : cspc_tb_top
`default_nettype wire
